// ---- core/psb_pkg.sv ----
package psb_pkg;
  localparam int NM = 2;
  localparam int NS = 2;
  localparam int AW = 32;
  localparam int DW = 32;
  localparam int OWN_W = $clog2(NM);
  localparam int SLV_W = $clog2(NS);
  localparam int SEL_W = $clog2(NS + 1);
  localparam logic [SEL_W-1:0] SEL_NONE = SEL_W'(NS);

  // transfer type
  localparam logic [1:0] TR_IDLE = 2'h0;
  localparam logic [1:0] TR_BUSY = 2'h1;
  localparam logic [1:0] TR_NONSEQ = 2'h2;
  localparam logic [1:0] TR_SEQ = 2'h3;

  // response
  localparam logic [1:0] RSP_OKAY = 2'h0;
  localparam logic [1:0] RSP_ERROR = 2'h1;
  localparam logic [1:0] RSP_RETRY = 2'h2;
  localparam logic [1:0] RSP_SPLIT = 2'h3;

  // burst and size codes driven by masters
  localparam logic [2:0] BU_SINGLE = 3'h0;
  localparam logic [2:0] BU_WRAP4 = 3'h2;
  localparam logic [2:0] BU_INCR4 = 3'h3;
  localparam logic [2:0] SZ_WORD = 3'h2;

  // command word: {kind, write, addr, wdata}
  localparam logic [1:0] KIND_SINGLE = 2'h0;
  localparam logic [1:0] KIND_INCR4 = 2'h1;
  localparam logic [1:0] KIND_WRAP4 = 2'h2;
  localparam int CMD_WD_LSB = 0;
  localparam int CMD_AD_LSB = 32;
  localparam int CMD_WR_BIT = 64;
  localparam int CMD_KIND_LSB = 65;
  localparam int CMD_W = 67;
  localparam logic [2:0] BEATS4 = 3'h4;
  localparam int FIFO_DEPTH = 16;

  // arbitration and reset values
  localparam logic [3:0] HOLD_MAX = 4'h8;
  localparam logic [NM-1:0] GRANT_ONE = NM'(1);

  // slave model: 16 words per slave, page = addr[31:28]
  localparam int SLV_WORDS = 16;
  localparam int SLV_IDX_W = 4;
  localparam int SLV_WAIT_STEP = 1;

  typedef enum logic [1:0] {DF_OK, DF_ERR1, DF_ERR2} psb_dflt_t;
  typedef enum logic [1:0] {SL_IDLE, SL_DATA, SL_FAIL1, SL_FAIL2} psb_slv_t;

  function automatic logic [SEL_W-1:0] slaveOf(input logic [AW-1:0] a);
    logic [SEL_W-1:0] r;
    r = SEL_NONE;
    for (int i = 0; i < NS; i++) begin
      if (a[AW-1:AW-4] == 4'(i)) r = SEL_W'(i);
    end
    return r;
  endfunction

  function automatic logic [AW-1:0] beatAddr(input logic [AW-1:0] base,
      input logic [1:0] kind, input logic [2:0] idx);
    logic [AW-1:0] a;
    logic [1:0] w;
    a = base + {{(AW-5){1'b0}}, idx, 2'h0};
    w = base[3:2] + idx[1:0];
    if (kind == KIND_WRAP4) a = {base[AW-1:4], w, base[1:0]};
    return a;
  endfunction
endpackage

// ---- core/psb_if.sv ----
`timescale 1ns/1ps
interface psb_if;
  // master side
  logic [psb_pkg::NM-1:0] req;
  logic [psb_pkg::NM-1:0] grant;
  logic [psb_pkg::AW-1:0] mAddr [psb_pkg::NM];
  logic [1:0] mTrans [psb_pkg::NM];
  logic mWrite [psb_pkg::NM];
  logic [2:0] mSize [psb_pkg::NM];
  logic [2:0] mBurst [psb_pkg::NM];
  logic [psb_pkg::DW-1:0] mWdata [psb_pkg::NM];
  // routed to every slave
  logic [psb_pkg::AW-1:0] sAddr;
  logic [1:0] sTrans;
  logic sWrite;
  logic [2:0] sSize;
  logic [2:0] sBurst;
  logic [psb_pkg::DW-1:0] sWdata;
  logic [psb_pkg::NS-1:0] sSel;
  // slave answers
  logic [psb_pkg::DW-1:0] sRdata [psb_pkg::NS];
  logic [psb_pkg::NS-1:0] sReady;
  logic [1:0] sResp [psb_pkg::NS];
  // returned to masters; ready is also every slave's ready input
  logic [psb_pkg::DW-1:0] rdata;
  logic ready;
  logic [1:0] resp;

  modport fabric(input req, mAddr, mTrans, mWrite, mSize, mBurst, mWdata,
    input sRdata, sReady, sResp,
    output grant, sAddr, sTrans, sWrite, sSize, sBurst, sWdata, sSel,
    output rdata, ready, resp);
  modport agents(output req, mAddr, mTrans, mWrite, mSize, mBurst, mWdata,
    output sRdata, sReady, sResp,
    input grant, sAddr, sTrans, sWrite, sSize, sBurst, sWdata, sSel,
    input rdata, ready, resp);
endinterface

// ---- core/psb_fifo.sv ----
`timescale 1ns/1ps
module psb_fifo #(
  parameter int WIDTH = psb_pkg::CMD_W,
  parameter int DEPTH = psb_pkg::FIFO_DEPTH
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // fill side
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  // drain side
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW:0] wp_r;
  logic [PW:0] rp_r;
  wire full = (wp_r[PW] != rp_r[PW]) && (wp_r[PW-1:0] == rp_r[PW-1:0]);
  wire empty = wp_r == rp_r;
  wire push = inValid && !full;
  wire pull = outReady && !empty;

  assign inReady = !full;
  assign outValid = !empty;
  assign outData = mem[rp_r[PW-1:0]];

  always_ff @(posedge clock) begin
    if (push) mem[wp_r[PW-1:0]] <= inData;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wp_r <= '0;
      rp_r <= '0;
    end else begin
      if (push) wp_r <= wp_r + 1'b1;
      if (pull) rp_r <= rp_r + 1'b1;
    end
  end
endmodule

// ---- core/psb_fabric.sv ----
`timescale 1ns/1ps
module psb_fabric (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // bus
  psb_if.fabric bus
);
  logic [psb_pkg::NM-1:0] grant_r;
  logic [psb_pkg::NM-1:0] grant_nxt;
  logic [psb_pkg::OWN_W-1:0] ownA_r;
  logic [psb_pkg::OWN_W-1:0] ownD_r;
  logic [psb_pkg::OWN_W-1:0] grantIdx;
  logic [psb_pkg::OWN_W-1:0] cand;
  logic found;
  logic [psb_pkg::SEL_W-1:0] selD_r;
  logic [3:0] hold_r;
  psb_pkg::psb_dflt_t df_r;
  psb_pkg::psb_dflt_t df_nxt;

  // address and control come from the address-phase owner, write data from the data-phase owner
  assign bus.sAddr = bus.mAddr[ownA_r];
  assign bus.sTrans = bus.mTrans[ownA_r];
  assign bus.sWrite = bus.mWrite[ownA_r];
  assign bus.sSize = bus.mSize[ownA_r];
  assign bus.sBurst = bus.mBurst[ownA_r];
  assign bus.sWdata = bus.mWdata[ownD_r];
  assign bus.grant = grant_r;

  wire addrActive = bus.sTrans[1];
  wire [psb_pkg::SEL_W-1:0] selA = psb_pkg::slaveOf(bus.sAddr);
  genvar s;
  for (s = 0; s < psb_pkg::NS; s++) begin : g_sel
    assign bus.sSel[s] = selA == psb_pkg::SEL_W'(s);
  end

  // return multiplexor follows the data-phase slave, not the address
  wire slvD = selD_r != psb_pkg::SEL_NONE;
  wire [psb_pkg::SLV_W-1:0] slvIdx = selD_r[psb_pkg::SLV_W-1:0];
  wire dfReady = df_r != psb_pkg::DF_ERR1;
  wire [1:0] dfResp = (df_r == psb_pkg::DF_OK) ?
    psb_pkg::RSP_OKAY : psb_pkg::RSP_ERROR;
  assign bus.ready = slvD ? bus.sReady[slvIdx] : dfReady;
  assign bus.resp = slvD ? bus.sResp[slvIdx] : dfResp;
  assign bus.rdata = slvD ? bus.sRdata[slvIdx] : '0;

  // unmapped page: two-cycle error; idle gets zero-wait okay
  always_comb begin
    df_nxt = df_r;
    if (df_r == psb_pkg::DF_ERR1) begin
      df_nxt = psb_pkg::DF_ERR2;
    end else if (bus.ready) begin
      if (addrActive && selA == psb_pkg::SEL_NONE) df_nxt = psb_pkg::DF_ERR1;
      else df_nxt = psb_pkg::DF_OK;
    end
  end

  always_comb begin
    grantIdx = '0;
    for (int i = 0; i < psb_pkg::NM; i++) begin
      if (grant_r[i]) grantIdx = psb_pkg::OWN_W'(i);
    end
  end

  // owner keeps the bus while requesting, cut after HOLD_MAX beats once another master requests
  always_comb begin
    grant_nxt = grant_r;
    found = 1'b0;
    cand = '0;
    if (!(bus.req[grantIdx] && hold_r < psb_pkg::HOLD_MAX)) begin
      for (int i = 1; i <= psb_pkg::NM; i++) begin
        cand = psb_pkg::OWN_W'((int'(grantIdx) + i) % psb_pkg::NM);
        if (!found && bus.req[cand]) begin
          grant_nxt = psb_pkg::GRANT_ONE << cand;
          found = 1'b1;
        end
      end
    end
  end

  wire ownBeat = addrActive && ownA_r == grantIdx;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      grant_r <= psb_pkg::GRANT_ONE;
      ownA_r <= '0;
      ownD_r <= '0;
      selD_r <= psb_pkg::SEL_NONE;
      hold_r <= '0;
      df_r <= psb_pkg::DF_OK;
    end else begin
      df_r <= df_nxt;
      // handover only at a ready edge: one cycle, no idle gap
      if (bus.ready) begin
        grant_r <= grant_nxt;
        ownA_r <= grantIdx;
        ownD_r <= ownA_r;
        selD_r <= addrActive ? selA : psb_pkg::SEL_NONE;
        if (grant_nxt != grant_r) hold_r <= '0;
        else if (ownBeat && hold_r != psb_pkg::HOLD_MAX) begin
          hold_r <= hold_r + 4'h1;
        end
      end
    end
  end
endmodule

// ---- core/psb_agents.sv ----
`timescale 1ns/1ps
module psb_agents (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // bus
  psb_if.agents bus,
  // master command streams
  input wire logic [psb_pkg::NM-1:0] cmdValid,
  output logic [psb_pkg::NM-1:0] cmdReady,
  input wire logic [psb_pkg::NM-1:0][psb_pkg::CMD_W-1:0] cmdData,
  // master results
  output logic [psb_pkg::NM-1:0] rspValid,
  output logic [psb_pkg::NM-1:0] rspErr,
  output logic [psb_pkg::NM-1:0][psb_pkg::DW-1:0] rspData,
  // slave control
  input wire logic [psb_pkg::NS-1:0] slaveBusy
);
  genvar m;
  genvar s;

  for (m = 0; m < psb_pkg::NM; m++) begin : g_mst
    logic [psb_pkg::CMD_W-1:0] head;
    logic hVal;
    logic pop;
    logic [2:0] aIdx_r;
    logic [2:0] dIdx_r;
    logic dPend_r;
    logic owns_r;
    logic contig_r;
    logic cancel_r;
    logic rv_r;
    logic re_r;
    logic [psb_pkg::DW-1:0] rd_r;

    // commands queue here so a stalled bus pushes back on the source
    psb_fifo #(
      .WIDTH(psb_pkg::CMD_W),
      .DEPTH(psb_pkg::FIFO_DEPTH)
    ) u_cmd (
      .clock(clock),
      .rst_n(rst_n),
      .inValid(cmdValid[m]),
      .inReady(cmdReady[m]),
      .inData(cmdData[m]),
      .outValid(hVal),
      .outReady(pop),
      .outData(head)
    );

    wire [1:0] kind = head[psb_pkg::CMD_KIND_LSB +: 2];
    wire wr = head[psb_pkg::CMD_WR_BIT];
    wire [psb_pkg::AW-1:0] base = head[psb_pkg::CMD_AD_LSB +: psb_pkg::AW];
    wire [psb_pkg::DW-1:0] wd = head[psb_pkg::CMD_WD_LSB +: psb_pkg::DW];
    wire [2:0] len = (kind == psb_pkg::KIND_SINGLE) ? 3'h1 : psb_pkg::BEATS4;
    wire left = hVal && (aIdx_r < len);
    // cancel_r forces idle in the second cycle of a failing response
    wire issue = left && owns_r && !cancel_r;
    wire done = bus.ready && dPend_r;
    wire isErr = bus.resp == psb_pkg::RSP_ERROR;
    wire failing = bus.resp != psb_pkg::RSP_OKAY;
    wire lastD = dIdx_r == len - 3'h1;
    wire okDone = done && !cancel_r;
    wire errDone = done && cancel_r && isErr;
    wire again = done && cancel_r && !isErr;
    wire [1:0] trNow = (aIdx_r == 3'h0 || !contig_r) ?
      psb_pkg::TR_NONSEQ : psb_pkg::TR_SEQ;
    wire [2:0] buNow = (kind == psb_pkg::KIND_INCR4) ? psb_pkg::BU_INCR4 :
      (kind == psb_pkg::KIND_WRAP4) ? psb_pkg::BU_WRAP4 : psb_pkg::BU_SINGLE;

    assign pop = (okDone && lastD) || errDone;
    assign bus.req[m] = left;
    assign bus.mTrans[m] = issue ? trNow : psb_pkg::TR_IDLE;
    assign bus.mAddr[m] = psb_pkg::beatAddr(base, kind, aIdx_r);
    assign bus.mWrite[m] = wr;
    assign bus.mSize[m] = psb_pkg::SZ_WORD;
    assign bus.mBurst[m] = buNow;
    // data follows the beat in data phase, fixed while it waits
    assign bus.mWdata[m] = wd + {{(psb_pkg::DW-3){1'b0}}, dIdx_r};
    assign rspValid[m] = rv_r;
    assign rspErr[m] = re_r;
    assign rspData[m] = rd_r;

    always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
        aIdx_r <= '0;
        dIdx_r <= '0;
        dPend_r <= 1'b0;
        owns_r <= 1'b0;
        contig_r <= 1'b0;
        cancel_r <= 1'b0;
        rv_r <= 1'b0;
        re_r <= 1'b0;
        rd_r <= '0;
      end else begin
        cancel_r <= !bus.ready && dPend_r && failing;
        rv_r <= okDone || errDone;
        if (bus.ready) begin
          owns_r <= bus.grant[m];
          dPend_r <= issue;
          // a lost grant or a retry breaks the sequence
          contig_r <= issue ||
            (bus.grant[m] && contig_r && !cancel_r);
          if (issue) begin
            dIdx_r <= aIdx_r;
            aIdx_r <= aIdx_r + 3'h1;
          end
          if (again) aIdx_r <= dIdx_r;
          if (errDone || (okDone && lastD)) aIdx_r <= '0;
          if (done) begin
            rd_r <= bus.rdata;
            re_r <= errDone;
          end
        end
      end
    end
  end

  for (s = 0; s < psb_pkg::NS; s++) begin : g_slv
    localparam logic [2:0] WAITS = 3'(s * psb_pkg::SLV_WAIT_STEP);
    logic [psb_pkg::DW-1:0] mem [psb_pkg::SLV_WORDS];
    psb_pkg::psb_slv_t st_r;
    psb_pkg::psb_slv_t st_nxt;
    logic [2:0] cnt_r;
    logic [psb_pkg::SLV_IDX_W-1:0] idx_r;
    logic wr_r;
    logic [1:0] fr_r;
    logic [psb_pkg::DW-1:0] rd_r;

    // idle and busy never start a data phase
    wire capture = bus.sSel[s] && bus.ready && bus.sTrans[1];
    wire [psb_pkg::SLV_IDX_W-1:0] idx = bus.sAddr[psb_pkg::SLV_IDX_W+1:2];
    wire inRange = bus.sAddr[27:psb_pkg::SLV_IDX_W+2] == '0;
    wire finish = st_r == psb_pkg::SL_DATA && cnt_r == 3'h0;
    wire doWrite = finish && wr_r;
    wire bypass = doWrite && idx_r == idx;

    assign bus.sReady[s] = (st_r == psb_pkg::SL_DATA) ? (cnt_r == 3'h0) :
      (st_r != psb_pkg::SL_FAIL1);
    assign bus.sResp[s] = (st_r == psb_pkg::SL_FAIL1 ||
      st_r == psb_pkg::SL_FAIL2) ? fr_r : psb_pkg::RSP_OKAY;
    assign bus.sRdata[s] = rd_r;

    always_comb begin
      st_nxt = psb_pkg::SL_IDLE;
      case (st_r)
        psb_pkg::SL_FAIL1: st_nxt = psb_pkg::SL_FAIL2;
        psb_pkg::SL_DATA: begin
          if (cnt_r != 3'h0) st_nxt = psb_pkg::SL_DATA;
          else if (capture && (slaveBusy[s] || !inRange)) begin
            st_nxt = psb_pkg::SL_FAIL1;
          end else if (capture) st_nxt = psb_pkg::SL_DATA;
        end
        psb_pkg::SL_IDLE, psb_pkg::SL_FAIL2: begin
          if (capture && (slaveBusy[s] || !inRange)) begin
            st_nxt = psb_pkg::SL_FAIL1;
          end else if (capture) st_nxt = psb_pkg::SL_DATA;
        end
        default: st_nxt = psb_pkg::SL_IDLE;
      endcase
    end

    always_ff @(posedge clock) begin
      if (doWrite) mem[idx_r] <= bus.sWdata;
    end

    always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
        st_r <= psb_pkg::SL_IDLE;
        cnt_r <= '0;
        idx_r <= '0;
        wr_r <= 1'b0;
        fr_r <= psb_pkg::RSP_OKAY;
        rd_r <= '0;
      end else begin
        st_r <= st_nxt;
        if (st_r == psb_pkg::SL_DATA && cnt_r != 3'h0) cnt_r <= cnt_r - 3'h1;
        // address and control are taken in the last cycle of their phase, when ready is high
        if (capture) begin
          idx_r <= idx;
          wr_r <= bus.sWrite;
          cnt_r <= WAITS;
          fr_r <= slaveBusy[s] ? psb_pkg::RSP_RETRY : psb_pkg::RSP_ERROR;
          rd_r <= bypass ? bus.sWdata : mem[idx];
        end
      end
    end
  end
endmodule

// ---- testbench/psb_checker.sv ----
`timescale 1ns/1ps
module psb_checker (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // master side
  input wire logic [psb_pkg::NM-1:0] grant,
  input wire logic [psb_pkg::AW-1:0] mAddr [psb_pkg::NM],
  input wire logic [1:0] mTrans [psb_pkg::NM],
  // routed to slaves
  input wire logic [psb_pkg::AW-1:0] sAddr,
  input wire logic [1:0] sTrans,
  input wire logic sWrite,
  input wire logic [2:0] sSize,
  input wire logic [2:0] sBurst,
  input wire logic [psb_pkg::DW-1:0] sWdata,
  input wire logic [psb_pkg::NS-1:0] sSel,
  // slave answers
  input wire logic [psb_pkg::DW-1:0] sRdata [psb_pkg::NS],
  input wire logic [psb_pkg::NS-1:0] sReady,
  input wire logic [1:0] sResp [psb_pkg::NS],
  // returned to masters
  input wire logic [psb_pkg::DW-1:0] rdata,
  input wire logic ready,
  input wire logic [1:0] resp
);
  logic [psb_pkg::OWN_W-1:0] addrOwner_r;
  logic [psb_pkg::SEL_W-1:0] dataSlave_r;
  logic idleData_r;
  logic wrData_r;
  logic [psb_pkg::OWN_W-1:0] dataOwner_r;
  logic [psb_pkg::AW-1:0] prevAddr_r;
  wire [psb_pkg::SEL_W-1:0] page = sAddr[31:28] < 4'(psb_pkg::NS) ?
      psb_pkg::SEL_W'(sAddr[31:28]) : psb_pkg::SEL_NONE;
  wire [psb_pkg::NS-1:0] selExp = page == psb_pkg::SEL_NONE ? '0 :
      psb_pkg::NS'(1) << page;
  wire [psb_pkg::SLV_W-1:0] ds = dataSlave_r[psb_pkg::SLV_W-1:0];
  // a sequential beat follows the beat taken at the last ready edge
  wire [psb_pkg::AW-1:0] incrNext = prevAddr_r + 32'h4;
  wire [psb_pkg::AW-1:0] wrapNext = {prevAddr_r[31:4],
      prevAddr_r[3:2] + 2'h1, prevAddr_r[1:0]};

  // shadow of the pipeline: only a ready edge moves address into data phase
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      addrOwner_r <= '0;
      dataSlave_r <= psb_pkg::SEL_NONE;
      idleData_r <= 1'b1;
      wrData_r <= 1'b0;
      dataOwner_r <= '0;
      prevAddr_r <= '0;
    end else if (ready) begin
      addrOwner_r <= psb_pkg::OWN_W'(grant[1]);
      dataOwner_r <= addrOwner_r;
      if (sTrans[1]) prevAddr_r <= sAddr;
      dataSlave_r <= sTrans[1] ? page : psb_pkg::SEL_NONE;
      idleData_r <= !sTrans[1];
      wrData_r <= sWrite && sTrans[1];
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  sequence failStart;
    !ready && resp != psb_pkg::RSP_OKAY;
  endsequence

  // only the master that got the response must fall idle; a new owner
  // of the address phase may already be issuing
  sequence failFinish;
    ready && $stable(resp) && mTrans[dataOwner_r] == psb_pkg::TR_IDLE;
  endsequence

  grant_onehot_a: assert property ($onehot(grant))
    else $error("grant not one-hot");
  grant_hold_a: assert property (!ready |=> $stable(grant))
    else $error("grant moved during a wait state");
  addr_route_a: assert property (sAddr == mAddr[addrOwner_r] &&
      sTrans == mTrans[addrOwner_r])
    else $error("address not from owning master");
  sel_decode_a: assert property (sSel == selExp)
    else $error("slave select does not match address page");
  rdata_mux_a: assert property (dataSlave_r != psb_pkg::SEL_NONE |->
      rdata == sRdata[ds] && ready == sReady[ds] && resp == sResp[ds])
    else $error("return path not from data-phase slave");
  idle_okay_a: assert property (idleData_r |->
      ready && resp == psb_pkg::RSP_OKAY)
    else $error("idle transfer not answered at once");
  unmapped_error_a: assert property (!idleData_r &&
      dataSlave_r == psb_pkg::SEL_NONE |-> resp == psb_pkg::RSP_ERROR)
    else $error("unmapped transfer not failed");
  fail_end_a: assert property (failStart |=> failFinish)
    else $error("failing response not two cycles");
  wdata_hold_a: assert property (wrData_r && !ready |=>
      $stable(sWdata))
    else $error("write data moved during wait");
  addr_hold_a: assert property (!ready && sTrans[1] &&
      resp == psb_pkg::RSP_OKAY |=> $stable(sAddr) && $stable(sTrans))
    else $error("next address moved during wait");
  ctrl_word_a: assert property (sTrans[1] |->
      sSize == psb_pkg::SZ_WORD && (sBurst == psb_pkg::BU_SINGLE ||
      sBurst == psb_pkg::BU_INCR4 || sBurst == psb_pkg::BU_WRAP4))
    else $error("control word not a legal word transfer");
  seq_step_a: assert property (sTrans == psb_pkg::TR_SEQ |->
      sAddr == (sBurst == psb_pkg::BU_WRAP4 ? wrapNext : incrNext))
    else $error("sequential beat address does not follow");
endmodule

// ---- testbench/test_pipelined_system_bus_fabric.sv ----
`timescale 1ns/1ps
module test_pipelined_system_bus_fabric;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [psb_pkg::NM-1:0] cmdValid = '0;
  logic [psb_pkg::NM-1:0] cmdReady;
  logic [psb_pkg::NM-1:0][psb_pkg::CMD_W-1:0] cmdData = '0;
  logic [psb_pkg::NM-1:0] rspValid;
  logic [psb_pkg::NM-1:0] rspErr;
  logic [psb_pkg::NM-1:0][psb_pkg::DW-1:0] rspData;
  logic [psb_pkg::NS-1:0] slaveBusy = '0;
  logic [31:0] mem [psb_pkg::NS][16];
  logic [33:0] expQ [psb_pkg::NM][$];
  int busyMode = 0;
  int errorCnt = 0;
  int samplesChecked = 0;

  psb_if bus();
  psb_fabric u_psb_fabric(.clock(clock), .rst_n(rst_n), .bus(bus));
  psb_agents u_psb_agents(.clock(clock), .rst_n(rst_n), .bus(bus),
    .cmdValid(cmdValid), .cmdReady(cmdReady), .cmdData(cmdData),
    .rspValid(rspValid), .rspErr(rspErr), .rspData(rspData),
    .slaveBusy(slaveBusy));
  psb_checker u_psb_checker(.clock(clock), .rst_n(rst_n),
    .grant(bus.grant), .mAddr(bus.mAddr), .mTrans(bus.mTrans),
    .sAddr(bus.sAddr), .sTrans(bus.sTrans), .sWrite(bus.sWrite),
    .sSize(bus.sSize), .sBurst(bus.sBurst),
    .sWdata(bus.sWdata), .sSel(bus.sSel), .sRdata(bus.sRdata),
    .sReady(bus.sReady), .sResp(bus.sResp), .rdata(bus.rdata),
    .ready(bus.ready), .resp(bus.resp));

  initial begin
    forever #12.5 clock = ~clock;
  end

  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    samplesChecked++;
    if (seen !== exp) begin
      errorCnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", samplesChecked, errorCnt);
    if (errorCnt == 0 && samplesChecked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // address of beat i: incrementing, or wrapping inside 16 bytes
  function automatic logic [31:0] beatOf(input logic [31:0] base,
      input logic [1:0] kind, input int i);
    logic [31:0] a;
    a = base + 32'(4 * i);
    if (kind == psb_pkg::KIND_WRAP4)
      a = {base[31:4], base[3:2] + 2'(i), base[1:0]};
    return a;
  endfunction

  // offer one command; expectations are logged only once it is taken
  task automatic issue(input int m, input logic [1:0] kind, input logic wr,
      input logic [31:0] base, input logic [31:0] wd, input int lim,
      output bit ok);
    logic [31:0] a;
    int s;
    int t;
    int n;
    cmdValid[m] <= 1'b1;
    cmdData[m] <= {kind, wr, base, wd};
    t = 0;
    @(negedge clock);
    while (cmdReady[m] !== 1'b1 && t < lim) begin
      @(negedge clock);
      t++;
    end
    ok = cmdReady[m] === 1'b1;
    @(posedge clock);
    if (!ok) cmdValid[m] <= 1'b0;
    n = (kind == psb_pkg::KIND_SINGLE) ? 1 : 4;
    for (int i = 0; ok && i < n; i++) begin
      a = beatOf(base, kind, i);
      s = int'(a[31:28]);
      if (s >= psb_pkg::NS || a[27:6] != 22'h0) begin
        expQ[m].push_back({!wr, 1'b1, 32'h0});
        break;
      end
      if (wr) mem[s][a[5:2]] = wd + 32'(i);
      expQ[m].push_back({!wr, 1'b0, wr ? 32'h0 : mem[s][a[5:2]]});
    end
  endtask

  // each master keeps to its own half of every slave, so reads are exact
  task automatic run(input int m, input int n);
    logic [31:0] a;
    int r;
    bit ok;
    for (int s = 0; s < psb_pkg::NS; s++) begin
      for (int j = 0; j < 2; j++) begin
        a = {4'(s), 22'h0, 1'(m), 3'(4 * j), 2'h0};
        issue(m, psb_pkg::KIND_INCR4, 1'b1, a, $urandom, 5000, ok);
      end
    end
    for (int k = 0; k < n; k++) begin
      r = $urandom_range(0, 9);
      a = {4'(r == 0 ? 2 : r % 2), 22'(r == 1), 1'(m),
        3'($urandom_range(0, 4)), 2'h0};
      issue(m, 2'($urandom_range(0, 2)), 1'($urandom), a, $urandom, 5000, ok);
    end
    cmdValid[m] <= 1'b0;
  endtask

  always @(posedge clock) begin
    for (int s = 0; s < psb_pkg::NS; s++)
      slaveBusy[s] <= busyMode == 2 || (busyMode == 1 &&
        $urandom_range(0, 3) == 0);
  end

  always @(posedge clock) begin
    logic [33:0] e;
    logic [33:0] seen;
    for (int m = 0; m < psb_pkg::NM; m++) begin
      if (rspValid[m] === 1'b1) begin
        e = expQ[m].size() > 0 ? expQ[m].pop_front() : '1;
        seen = {e[33], rspErr[m], (e[33] && rspErr[m] === 1'b0) ?
          rspData[m] : 32'h0};
        check(seen, e);
      end
    end
  end

  initial begin
    #(25 * 90000);
    errorCnt++;
    conclude();
  end

  initial begin
    int n;
    bit ok;
    void'($urandom(32'hf6b4));
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    busyMode = 1;
    fork
      run(0, 40);
      run(1, 40);
    join
    // start from an empty queue so that the refusal count is exact
    for (int t = 0; t < 20000 && expQ[0].size() + expQ[1].size() > 0; t++)
      @(posedge clock);
    // every slave retries, so master 0's queue fills and must refuse
    busyMode = 2;
    n = 0;
    ok = 1'b1;
    while (ok && n < 20) begin
      issue(0, psb_pkg::KIND_SINGLE, 1'b1, {28'h0, 4'(n % 8), 2'h0},
        $urandom, 30, ok);
      n += int'(ok);
    end
    check(34'(n >= psb_pkg::FIFO_DEPTH), 34'h1);
    check(34'(cmdReady[0]), 34'h0);
    busyMode = 1;
    for (int t = 0; t < 20000 && expQ[0].size() + expQ[1].size() > 0; t++)
      @(posedge clock);
    check(34'(expQ[0].size() + expQ[1].size()), 34'h0);
    repeat (10) @(posedge clock);
    conclude();
  end
endmodule
